/* include/iam_pkg.sv */
// constants shared by the alarm monitor files
// assumes a single 25 MHz device clock and 16-bit SPI frames from the host
package iam_pkg;
    // sensor streams and word widths
    localparam int NUM_SRC   = 7;
    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 7;
    localparam int SPI_BITS  = 16;

    // register byte addresses (low byte at the even address)
    localparam logic [6:0] ADDR_THR1  = 7'h26;
    localparam logic [6:0] ADDR_THR2  = 7'h28;
    localparam logic [6:0] ADDR_CNT1  = 7'h2A;
    localparam logic [6:0] ADDR_CNT2  = 7'h2C;
    localparam logic [6:0] ADDR_CFG   = 7'h2E;
    localparam logic [6:0] ADDR_DIAG  = 7'h3C;

    // values after reset
    localparam logic [15:0] THR_RESET  = 16'h0000;
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [15:0] CFG_RESET  = 16'h0000;
    localparam logic [1:0]  DIAG_RESET = 2'h0;

    // writable bits; unused bits are dropped and read back as zero
    localparam logic [15:0] THR_MASK = 16'hBFFF;
    localparam logic [15:0] CNT_MASK = 16'h00FF;
    localparam logic [15:0] CFG_MASK = 16'hFFD7;

    // field positions
    localparam int THR_POL    = 15;
    localparam int THR_MSB    = 13;
    localparam int CNT_MSB    = 7;
    localparam int CFG_SRC2   = 12;
    localparam int CFG_SRC1   = 8;
    localparam int CFG_DYN2   = 7;
    localparam int CFG_DYN1   = 6;
    localparam int CFG_FILT   = 4;
    localparam int CFG_IND_EN = 2;
    localparam int CFG_IND_HI = 1;
    localparam int CFG_IND_LN = 0;
    localparam int DIAG_ALM1  = 8;
    localparam int SPI_WR_BIT = 15;

    // source codes
    localparam logic [3:0] SRC_OFF  = 4'h0;
    localparam logic [3:0] SRC_LAST = 4'h7;

    // history depth in samples
    localparam int HIST_DEPTH = 256;
endpackage

/* sim/iam_alarm_monitor_bench.sv */
// self-checking bench for the alarm monitor
// assumes the host model and the bound checker are compiled before it
module iam_alarm_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic             ref_clk_i    = 1'b0;
    logic             rst_n_i      = 1'b0;
    logic             tick         = 1'b0;
    logic             md_en        = 1'b0;
    logic             md_line      = 1'b0;
    logic             md_lvl       = 1'b0;
    logic [1:0]       g_dir        = 2'h0;
    logic [1:0]       g_lvl        = 2'h0;
    logic [6:0][15:0] raw          = '0;
    logic [6:0][15:0] filt         = '0;
    logic             sclk, cs_n, mosi, miso, miso_oe, l1, l1_oe, l2, l2_oe;
    logic [1:0]       act;
    logic [15:0]      rd;
    int               mismatches   = 0;
    int               total_checks = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    iam_alarm_monitor uut (
        .ref_clk_i, .rst_n_i, .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_o(miso_oe), .sample_tick_i(tick), .src_raw_i(raw), .src_filt_i(filt),
        .misc_dr_en_i(md_en), .misc_dr_line_i(md_line), .misc_dr_level_i(md_lvl),
        .gpio_dir_i(g_dir), .gpio_level_i(g_lvl), .gp_line_one_o(l1),
        .gp_line_one_oe_o(l1_oe), .gp_line_two_o(l2), .gp_line_two_oe_o(l2_oe),
        .alarm_active_o(act)
    );
    iam_host_model host (
        .ref_clk_i, .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
        .miso_oe_i(miso_oe)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] v);
        logic [15:0] r;
        host.xfer({1'b1, a, v[7:0]}, r);
        host.xfer({1'b1, a | 7'h01, v[15:8]}, r);
    endtask
    // the answer to a read arrives in the following frame
    task automatic rdreg(input logic [6:0] a);
        host.xfer({1'b0, a, 8'h00}, rd);
        host.xfer(16'h0000, rd);
    endtask
    task automatic sample(input int n);
        repeat (n) begin
            @(negedge ref_clk_i) tick = 1'b1;
            @(negedge ref_clk_i) tick = 1'b0;
            repeat (3) @(negedge ref_clk_i);
        end
    endtask
    task automatic t_reset;
        logic [6:0] regs [6] = '{iam_pkg::ADDR_THR1, iam_pkg::ADDR_THR2, iam_pkg::ADDR_CNT1,
                                 iam_pkg::ADDR_CNT2, iam_pkg::ADDR_CFG, 7'h30};
        foreach (regs[i]) begin
            rdreg(regs[i]);
            check(rd, 16'h0000, "reset value");
        end
    endtask
    task automatic t_masks;
        wr(iam_pkg::ADDR_THR1, 16'hFFFF);
        rdreg(iam_pkg::ADDR_THR1);
        check(rd, 16'hBFFF, "threshold bits");
        wr(iam_pkg::ADDR_CNT2, 16'hFFFF);
        rdreg(iam_pkg::ADDR_CNT2);
        check(rd, 16'h00FF, "count bits");
        wr(iam_pkg::ADDR_CFG, 16'hFFFF);
        rdreg(iam_pkg::ADDR_CFG);
        check(rd, 16'hFFD7, "config bits");
        wr(iam_pkg::ADDR_CFG, 16'h0000);
    endtask
    // source codes 0 to 7 on both alarms, static greater than zero, unfiltered
    task automatic t_sources;
        host.half = 4;
        wr(iam_pkg::ADDR_THR1, 16'h8000);
        wr(iam_pkg::ADDR_THR2, 16'h8000);
        for (int c = 0; c < 8; c++) begin
            raw = {7{16'hFFFB}};
            filt = {7{16'h0005}};
            if (c > 0) begin
                raw[c-1] = 16'h0005;
                filt[c-1] = 16'hFFFB;
            end
            wr(iam_pkg::ADDR_CFG, {c[3:0], c[3:0], 8'h00});
            sample(1);
            check({14'h0, act}, (c > 0) ? 16'h0003 : 16'h0000, "source code");
        end
        host.half = 8;
    endtask
    task automatic t_static;
        rdreg(iam_pkg::ADDR_DIAG);
        check(rd, 16'h0300, "diag both flags");
        raw[5] = 16'h7000;
        filt[5] = 16'h0064;
        wr(iam_pkg::ADDR_THR1, 16'h02BC);
        wr(iam_pkg::ADDR_CFG, 16'h0617);
        sample(1);
        check({14'h0, act}, 16'h0001, "static less, filtered");
        check({13'h0, l1_oe, l2_oe, l2}, 16'h0003, "indicator line two");
        rdreg(iam_pkg::ADDR_DIAG);
        check(rd, 16'h0100, "diag flag");
        rdreg(iam_pkg::ADDR_DIAG);
        check(rd, 16'h0000, "diag cleared");
        sample(1);
        rdreg(iam_pkg::ADDR_DIAG);
        check(rd, 16'h0100, "diag set again");
        filt[5] = 16'h03E8;
        sample(1);
        check({13'h0, act, l2}, 16'h0000, "inactive high polarity");
        wr(iam_pkg::ADDR_CFG, 16'h0615);
        sample(1);
        check({15'h0, l2}, 16'h0001, "inactive low polarity");
        filt[5] = 16'h0064;
        sample(1);
        check({14'h0, l2_oe, l2}, 16'h0002, "active low polarity");
        wr(iam_pkg::ADDR_CFG, 16'h0611);
        check({14'h0, l2_oe, l1_oe}, 16'h0000, "indicator off");
    endtask
    task automatic t_dynamic;
        raw[2] = 16'h0000;
        wr(iam_pkg::ADDR_THR2, 16'h800A);
        wr(iam_pkg::ADDR_CNT2, 16'h0002);
        wr(iam_pkg::ADDR_CFG, 16'h3080);
        sample(3);
        check({14'h0, act}, 16'h0000, "flat source");
        raw[2] = 16'h0014;
        sample(1);
        check({14'h0, act}, 16'h0002, "step seen");
        sample(1);
        check({14'h0, act}, 16'h0002, "two samples back");
        sample(1);
        check({14'h0, act}, 16'h0000, "step aged out");
        wr(iam_pkg::ADDR_CNT2, 16'h0000);
        sample(2);
        raw[2] = 16'h0028;
        sample(1);
        check({14'h0, act}, 16'h0002, "count zero step");
        sample(1);
        check({14'h0, act}, 16'h0000, "count zero is one");
    endtask
    task automatic t_priority;
        filt[5] = 16'h0064;
        wr(iam_pkg::ADDR_CFG, 16'h0616);
        sample(1);
        check({14'h0, l1_oe, l1}, 16'h0003, "indicator line one");
        g_dir = 2'b11;
        g_lvl = 2'b10;
        repeat (3) @(negedge ref_clk_i);
        check({12'h0, l1_oe, l1, l2_oe, l2}, 16'h000F, "alarm over gpio");
        md_en = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        check({14'h0, l1_oe, l1}, 16'h0002, "misc over alarm");
        md_line = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        check({12'h0, l1_oe, l1, l2_oe, l2}, 16'h000E, "misc over gpio");
        md_en = 1'b0;
        g_dir = 2'b00;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        t_reset;
        t_masks;
        t_sources;
        t_static;
        t_dynamic;
        t_priority;
        wrap_up;
    end
    // 72 frames of under 300 clocks each, with room to spare
    initial begin
        repeat (90000) @(posedge ref_clk_i);
        mismatches++;
        wrap_up;
    end
endmodule

/* sim/iam_alarm_monitor_properties.sv */
// assertions on the alarm monitor top ports
// assumes one clock domain; bound onto every instance of the top module
module iam_alarm_monitor_properties (
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    input wire logic       cs_n_i,
    input wire logic       miso_oe_o,
    input wire logic       sample_tick_i,
    input wire logic       misc_dr_en_i,
    input wire logic       misc_dr_line_i,
    input wire logic       misc_dr_level_i,
    input wire logic       gp_line_one_o,
    input wire logic       gp_line_one_oe_o,
    input wire logic       gp_line_two_o,
    input wire logic       gp_line_two_oe_o,
    input wire logic [1:0] alarm_active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // five edges cover the two-flop select sync plus the output flop
    sequence s_sel;
        !cs_n_i [*5];
    endsequence
    sequence s_idle;
        cs_n_i [*5];
    endsequence
    // a command lands about four clocks after select rises; nine idle edges clear it
    sequence s_quiet;
        cs_n_i [*8] ##1 (cs_n_i && !$past(sample_tick_i, 2));
    endsequence
    property p_oe_on;
        s_sel |-> miso_oe_o;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso enable low while selected");
    property p_oe_off;
        s_idle |-> !miso_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso enable high while idle");
    property p_misc_one;
        misc_dr_en_i && !misc_dr_line_i |=>
            gp_line_one_oe_o && gp_line_one_o == $past(misc_dr_level_i);
    endproperty
    a_misc_one: assert property (p_misc_one) else $error("line one not data ready");
    property p_misc_two;
        misc_dr_en_i && misc_dr_line_i |=>
            gp_line_two_oe_o && gp_line_two_o == $past(misc_dr_level_i);
    endproperty
    a_misc_two: assert property (p_misc_two) else $error("line two not data ready");
    property p_undriven;
        !gp_line_one_oe_o && !gp_line_two_oe_o |-> !gp_line_one_o && !gp_line_two_o;
    endproperty
    a_undriven: assert property (p_undriven) else $error("undriven line not low");
    property p_rise_one;
        $rose(alarm_active_o[0]) |-> $past(sample_tick_i, 2);
    endproperty
    a_rise_one: assert property (p_rise_one) else $error("alarm one rose off tick");
    property p_rise_two;
        $rose(alarm_active_o[1]) |-> $past(sample_tick_i, 2);
    endproperty
    a_rise_two: assert property (p_rise_two) else $error("alarm two rose off tick");
    property p_quiet;
        s_quiet |-> $stable(alarm_active_o);
    endproperty
    a_quiet: assert property (p_quiet) else $error("alarm moved with no cause");
endmodule

bind iam_alarm_monitor iam_alarm_monitor_properties u_props (
    .ref_clk_i, .rst_n_i, .cs_n_i, .miso_oe_o, .sample_tick_i, .misc_dr_en_i,
    .misc_dr_line_i, .misc_dr_level_i, .gp_line_one_o, .gp_line_one_oe_o,
    .gp_line_two_o, .gp_line_two_oe_o, .alarm_active_o
);

/* sim/iam_host_model.sv */
// host processor model: spi master, mode 3, 16-bit frames, msb first
// assumes the device samples mosi on sclk rising and shifts miso after falling
module iam_host_model (
    input  wire logic ref_clk_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    input  wire logic miso_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ref clocks per sclk half period; 3 is the fastest the port accepts
    int half = 8;
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        @(negedge ref_clk_i) cs_n_o = 1'b0;
        repeat (half) @(negedge ref_clk_i);
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b0;
            mosi_o = w[i];
            repeat (half) @(negedge ref_clk_i);
            sclk_o = 1'b1;
            // an unselected miso must never pass for data
            r[i] = miso_oe_i ? miso_i : 1'bx;
            repeat (half) @(negedge ref_clk_i);
        end
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (12) @(negedge ref_clk_i);
    endtask
endmodule

/* src/iam_alarm_channel.sv */
// one alarm: static level test or change over n samples
// assumes sample_tick_i is a one-cycle pulse on ref_clk_i with src_i valid
module iam_alarm_channel #(
    parameter int DEPTH = iam_pkg::HIST_DEPTH
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sample_tick_i,
    input  wire logic        restart_i,
    input  wire logic        enable_i,
    input  wire logic        dynamic_i,
    input  wire logic [7:0]  count_i,
    input  wire logic [15:0] threshold_i,
    input  wire logic [15:0] src_i,
    output logic             hit_o,
    output logic             hit_stb_o
);
    typedef struct packed {
        logic [7:0] wp;
        logic [8:0] fill;
        logic       hit;
        logic       stb;
    } iam_chan_t;

    iam_chan_t   st_reg;
    iam_chan_t   st_next;
    logic [15:0] hist [DEPTH];

    always_comb begin
        logic [7:0]         n;
        logic signed [16:0] val;
        logic signed [16:0] thr;
        logic               cond;
        logic               ready;
        n     = (count_i == 8'h00) ? 8'h01 : count_i;
        thr   = 17'(signed'(threshold_i[iam_pkg::THR_MSB:0]));
        val   = 17'(signed'(src_i));
        if (dynamic_i) begin
            // change against the sample n ticks back
            val = val - 17'(signed'(hist[st_reg.wp - n]));
        end
        cond  = threshold_i[iam_pkg::THR_POL] ? (val > thr) : (val < thr);
        // in dynamic mode, no verdict until the history holds n samples
        ready = enable_i && (!dynamic_i || (st_reg.fill >= {1'b0, n}));
        st_next     = st_reg;
        st_next.stb = 1'b0;
        if (restart_i) begin
            st_next.fill = 9'h000;
            st_next.hit  = 1'b0;
        end else if (sample_tick_i) begin
            st_next.wp  = st_reg.wp + 8'h01;
            if (st_reg.fill != 9'(DEPTH)) begin
                st_next.fill = st_reg.fill + 9'h001;
            end
            st_next.hit = ready && cond;
            st_next.stb = ready && cond;
        end
    end

    // history kept without reset; fill count guards the stale words
    always_ff @(posedge ref_clk_i) begin
        if (sample_tick_i) begin
            hist[st_reg.wp] <= src_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hit_o     = st_reg.hit;
    assign hit_stb_o = st_reg.stb;
endmodule

/* src/iam_alarm_monitor.sv */
// two alarm monitors with spi register access and indicator routing
// assumes sensor streams and sample tick come from logic on ref_clk_i
//
// Notes on behaviour
// - two alarms, separate settings except the shared filter bit and restart
// - static test, threshold bit 15 picks greater/less
// - threshold bits 13:0, source number format
// - dynamic mode tests change over sample count
// - sample count 8 bits, zero means one
// - config bits 15:12 pick alarm two source
// - config bits 11:8 pick alarm one source
// - bits 7/6 select dynamic for alarms two/one
// - config bit 4 selects filtered source data
// - config bit 2 enables line indicator
// - config bit 1 sets indicator active level
// - config bit 0 picks line two, else one
// - diagnostic bits 9 and 8 show alarms
// - line priority: misc, alarm, then gpio
// - diagnostic flags clear on read, resample later
module iam_alarm_monitor (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // host spi pins
    input  wire logic                  sclk_i,
    input  wire logic                  cs_n_i,
    input  wire logic                  mosi_i,
    output logic                       miso_o,
    output logic                       miso_oe_o,
    // sensor streams: gyro x,y,z, accel x,y,z, temperature
    input  wire logic                  sample_tick_i,
    input  wire logic [6:0][15:0]      src_raw_i,
    input  wire logic [6:0][15:0]      src_filt_i,
    // other claimants of the general-purpose lines
    input  wire logic                  misc_dr_en_i,
    input  wire logic                  misc_dr_line_i,
    input  wire logic                  misc_dr_level_i,
    input  wire logic [1:0]            gpio_dir_i,
    input  wire logic [1:0]            gpio_level_i,
    // general-purpose lines
    output logic                       gp_line_one_o,
    output logic                       gp_line_one_oe_o,
    output logic                       gp_line_two_o,
    output logic                       gp_line_two_oe_o,
    output logic [1:0]                 alarm_active_o
);
    typedef struct packed {
        logic [15:0] thr1;
        logic [15:0] thr2;
        logic [15:0] cnt1;
        logic [15:0] cnt2;
        logic [15:0] cfg;
        logic [1:0]  diag;
        logic [15:0] rd;
        logic        restart;
        logic        l1;
        logic        l1_oe;
        logic        l2;
        logic        l2_oe;
        logic [1:0]  act;
    } iam_state_t;

    iam_state_t  st_reg;
    iam_state_t  st_next;
    logic        cmd_stb;
    logic [15:0] cmd_word;
    logic [1:0]  hit;
    logic [1:0]  hit_stb;
    logic [15:0] src_sel [2];

    // codes above seven behave as disabled
    function automatic logic [15:0] pick_src(input logic [3:0]       code,
                                             input logic             filt,
                                             input logic [6:0][15:0] raw,
                                             input logic [6:0][15:0] flt);
        logic [2:0] idx;
        idx = 3'(code - 4'h1);
        if (code == iam_pkg::SRC_OFF || code > iam_pkg::SRC_LAST) begin
            pick_src = 16'h0000;
        end else if (filt) begin
            pick_src = flt[idx];
        end else begin
            pick_src = raw[idx];
        end
    endfunction

    function automatic logic src_on(input logic [3:0] code);
        src_on = (code != iam_pkg::SRC_OFF) && (code <= iam_pkg::SRC_LAST);
    endfunction

    // one gp line: misc control first, then the alarm, then plain gpio
    function automatic logic [1:0] line_drive(input logic dr_own,
                                              input logic dr_lvl,
                                              input logic al_own,
                                              input logic al_lvl,
                                              input logic io_out,
                                              input logic io_lvl);
        if (dr_own) begin
            line_drive = {1'b1, dr_lvl};
        end else if (al_own) begin
            line_drive = {1'b1, al_lvl};
        end else if (io_out) begin
            line_drive = {1'b1, io_lvl};
        end else begin
            line_drive = 2'b00;
        end
    endfunction

    iam_spi_port u_spi (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .sclk_i     (sclk_i),
        .cs_n_i     (cs_n_i),
        .mosi_i     (mosi_i),
        .tx_word_i  (st_reg.rd),
        .miso_o     (miso_o),
        .miso_oe_o  (miso_oe_o),
        .cmd_stb_o  (cmd_stb),
        .cmd_word_o (cmd_word)
    );

    assign src_sel[0] = pick_src(st_reg.cfg[iam_pkg::CFG_SRC1 +: 4], st_reg.cfg[iam_pkg::CFG_FILT],
                                 src_raw_i, src_filt_i);
    assign src_sel[1] = pick_src(st_reg.cfg[iam_pkg::CFG_SRC2 +: 4], st_reg.cfg[iam_pkg::CFG_FILT],
                                 src_raw_i, src_filt_i);

    // two identical channels, each with its own settings
    iam_alarm_channel u_alarm1 (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .sample_tick_i (sample_tick_i),
        .restart_i     (st_reg.restart),
        .enable_i      (src_on(st_reg.cfg[iam_pkg::CFG_SRC1 +: 4])),
        .dynamic_i     (st_reg.cfg[iam_pkg::CFG_DYN1]),
        .count_i       (st_reg.cnt1[iam_pkg::CNT_MSB:0]),
        .threshold_i   (st_reg.thr1),
        .src_i         (src_sel[0]),
        .hit_o         (hit[0]),
        .hit_stb_o     (hit_stb[0])
    );

    iam_alarm_channel u_alarm2 (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .sample_tick_i (sample_tick_i),
        .restart_i     (st_reg.restart),
        .enable_i      (src_on(st_reg.cfg[iam_pkg::CFG_SRC2 +: 4])),
        .dynamic_i     (st_reg.cfg[iam_pkg::CFG_DYN2]),
        .count_i       (st_reg.cnt2[iam_pkg::CNT_MSB:0]),
        .threshold_i   (st_reg.thr2),
        .src_i         (src_sel[1]),
        .hit_o         (hit[1]),
        .hit_stb_o     (hit_stb[1])
    );

    always_comb begin
        logic [6:0]  addr;
        logic [6:0]  base;
        logic [7:0]  data;
        logic        hi;
        logic        wr;
        logic [1:0]  clr;
        logic        ind;
        logic [1:0]  d1;
        logic [1:0]  d2;
        addr = cmd_word[14:8];
        base = {addr[6:1], 1'b0};
        data = cmd_word[7:0];
        hi   = addr[0];
        wr   = cmd_stb && cmd_word[iam_pkg::SPI_WR_BIT];
        clr  = 2'b00;
        st_next         = st_reg;
        st_next.restart = 1'b0;

        // byte writes: even address low byte, odd address high byte
        if (wr) begin
            case (base)
                iam_pkg::ADDR_THR1: begin
                    if (hi) st_next.thr1[15:8] = data & iam_pkg::THR_MASK[15:8];
                    else    st_next.thr1[7:0]  = data & iam_pkg::THR_MASK[7:0];
                end
                iam_pkg::ADDR_THR2: begin
                    if (hi) st_next.thr2[15:8] = data & iam_pkg::THR_MASK[15:8];
                    else    st_next.thr2[7:0]  = data & iam_pkg::THR_MASK[7:0];
                end
                iam_pkg::ADDR_CNT1: begin
                    if (!hi) st_next.cnt1[7:0] = data;
                    st_next.restart = 1'b1;
                end
                iam_pkg::ADDR_CNT2: begin
                    if (!hi) st_next.cnt2[7:0] = data;
                    st_next.restart = 1'b1;
                end
                iam_pkg::ADDR_CFG: begin
                    if (hi) st_next.cfg[15:8] = data & iam_pkg::CFG_MASK[15:8];
                    else    st_next.cfg[7:0]  = data & iam_pkg::CFG_MASK[7:0];
                    // new source or mode: old history no longer applies
                    st_next.restart = 1'b1;
                end
                default: begin
                end
            endcase
        end else if (cmd_stb) begin
            // reply goes out in the following frame
            case (base)
                iam_pkg::ADDR_THR1: st_next.rd = st_reg.thr1;
                iam_pkg::ADDR_THR2: st_next.rd = st_reg.thr2;
                iam_pkg::ADDR_CNT1: st_next.rd = st_reg.cnt1;
                iam_pkg::ADDR_CNT2: st_next.rd = st_reg.cnt2;
                iam_pkg::ADDR_CFG:  st_next.rd = st_reg.cfg;
                iam_pkg::ADDR_DIAG: begin
                    st_next.rd = 16'(st_reg.diag) << iam_pkg::DIAG_ALM1;
                    clr        = 2'b11;
                end
                default: st_next.rd = 16'h0000;
            endcase
        end

        // a flag clears on read; a hit in that same cycle still sets it
        st_next.diag = (st_reg.diag & ~clr) | hit_stb;

        // indicator level from the live alarm state
        ind = st_reg.cfg[iam_pkg::CFG_IND_HI] ? (|hit) : !(|hit);
        // misc control outranks alarm, alarm outranks gpio
        d1 = line_drive(misc_dr_en_i && !misc_dr_line_i, misc_dr_level_i,
                        st_reg.cfg[iam_pkg::CFG_IND_EN] && !st_reg.cfg[iam_pkg::CFG_IND_LN], ind,
                        gpio_dir_i[0], gpio_level_i[0]);
        d2 = line_drive(misc_dr_en_i && misc_dr_line_i, misc_dr_level_i,
                        st_reg.cfg[iam_pkg::CFG_IND_EN] && st_reg.cfg[iam_pkg::CFG_IND_LN], ind,
                        gpio_dir_i[1], gpio_level_i[1]);
        st_next.l1_oe = d1[1];
        st_next.l1    = d1[0];
        st_next.l2_oe = d2[1];
        st_next.l2    = d2[0];
        st_next.act   = hit;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg      <= '0;
            st_reg.thr1 <= iam_pkg::THR_RESET;
            st_reg.thr2 <= iam_pkg::THR_RESET;
            st_reg.cnt1 <= iam_pkg::CNT_RESET;
            st_reg.cnt2 <= iam_pkg::CNT_RESET;
            st_reg.cfg  <= iam_pkg::CFG_RESET;
            st_reg.diag <= iam_pkg::DIAG_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign gp_line_one_o    = st_reg.l1;
    assign gp_line_one_oe_o = st_reg.l1_oe;
    assign gp_line_two_o    = st_reg.l2;
    assign gp_line_two_oe_o = st_reg.l2_oe;
    assign alarm_active_o   = st_reg.act;
endmodule

/* src/iam_spi_port.sv */
// spi slave, mode 3, 16-bit frames, msb first
// assumes sclk well below a quarter of ref_clk_i; all pins pass two flops
module iam_spi_port (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    input  wire logic [15:0] tx_word_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    output logic             cmd_stb_o,
    output logic      [15:0] cmd_word_o
);
    typedef struct packed {
        logic [2:0]  s1;
        logic [2:0]  s2;
        logic        sclk_d;
        logic        cs_d;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [4:0]  bits;
        logic        miso;
        logic        oe;
        logic        stb;
        logic [15:0] word;
    } iam_spi_t;

    iam_spi_t st_reg;
    iam_spi_t st_next;
    localparam int SPI_BITS_C = iam_pkg::SPI_BITS;

    always_comb begin
        logic sclk;
        logic cs;
        logic mosi;
        sclk = st_reg.s2[2];
        cs   = st_reg.s2[1];
        mosi = st_reg.s2[0];
        st_next        = st_reg;
        st_next.s1     = {sclk_i, cs_n_i, mosi_i};
        st_next.s2     = st_reg.s1;
        st_next.sclk_d = sclk;
        st_next.cs_d   = cs;
        st_next.stb    = 1'b0;
        if (st_reg.cs_d && !cs) begin
            // reply to the previous frame is frozen at select
            st_next.tx   = tx_word_i;
            st_next.bits = 5'h00;
            st_next.oe   = 1'b1;
        end else if (!st_reg.cs_d && cs) begin
            // only a frame of 16 or more bits counts as a command; the last 16 are kept
            st_next.oe = 1'b0;
            if (st_reg.bits == 5'(SPI_BITS_C)) begin
                st_next.stb  = 1'b1;
                st_next.word = st_reg.rx;
            end
        end else if (!cs) begin
            if (!st_reg.sclk_d && sclk) begin
                st_next.rx = {st_reg.rx[14:0], mosi};
                if (st_reg.bits != 5'(SPI_BITS_C)) begin
                    st_next.bits = st_reg.bits + 5'h01;
                end
            end
            if (st_reg.sclk_d && !sclk) begin
                st_next.miso = st_reg.tx[15];
                st_next.tx   = {st_reg.tx[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg        <= '0;
            st_reg.s1     <= 3'h7;
            st_reg.s2     <= 3'h7;
            st_reg.sclk_d <= 1'b1;
            st_reg.cs_d   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign miso_o     = st_reg.miso;
    assign miso_oe_o  = st_reg.oe;
    assign cmd_stb_o  = st_reg.stb;
    assign cmd_word_o = st_reg.word;
endmodule
